// >>> rpc_pkg.sv
// Purpose: Shared constants for the read-parameter command link
// Assumes: SPI mode 0/3, single-bit serial lines, 8-bit command codes
// Notes:   Register layouts and command codes for the flash side; host register map for the controller
package rpc_pkg;
    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_WREN    = 8'h06;
    localparam logic [7:0] CMD_SRP_NV  = 8'h65;
    localparam logic [7:0] CMD_SRP_VW  = 8'h63;
    localparam logic [7:0] CMD_SRP_VF  = 8'hC0;
    localparam logic [7:0] CMD_SEP_NV  = 8'h85;
    localparam logic [7:0] CMD_SEP_V   = 8'h83;
    localparam logic [7:0] CMD_RD_RP   = 8'h61;
    localparam logic [7:0] CMD_RD_EP   = 8'h81;
    localparam logic [7:0] CMD_CLR_EP  = 8'h82;
    localparam logic [7:0] CMD_LEG_ID  = 8'hAB;
    localparam logic [7:0] CMD_READ    = 8'h03;
    // ----------------------------------------
    // Read parameter fields
    // ----------------------------------------
    localparam int RP_WRAP_EN_BIT  = 2;
    localparam int RP_HOLD_SEL_BIT = 7;
    localparam int RP_DUMMY_LSB    = 3;
    localparam logic [7:0] RP_RESET    = 8'h00;
    // ----------------------------------------
    // Extended register fields
    // ----------------------------------------
    localparam int EP_WIP_BIT      = 0;
    localparam int EP_PROTECTION_ERROR_FLAG_BIT   = 1;
    localparam int EP_PERR_BIT     = 2;
    localparam int EP_EERR_BIT     = 3;
    localparam int EP_ODS_LSB      = 5;
    localparam logic [7:0] EP_ERR_MASK = 8'h0E;
    localparam logic [7:0] EP_ODS_MASK = 8'hE0;
    localparam logic [7:0] EP_RESET    = 8'hE0;
    // ----------------------------------------
    // Misc
    // ----------------------------------------
    localparam int LEG_ID_DUMMY_BYTES = 3;
    localparam int PAGE_BYTES         = 256;
    localparam int ADDR_BYTES         = 3;
    // Host register map over AHB-Lite
    localparam logic [7:0] HR_CTRL   = 8'h00;
    localparam logic [7:0] HR_TX     = 8'h04;
    localparam logic [7:0] HR_RX     = 8'h08;
    localparam logic [7:0] HR_STATUS = 8'h0C;
    localparam logic [7:0] HR_DIV    = 8'h10;
    localparam logic [7:0] DIV_RESET = 8'h04;
endpackage

// >>> rpc_link_if.sv
// Purpose: Serial link between flash-side command logic and controller
// Assumes: Single-bit data in, single-bit data out with enable
// Notes:   The controller resolves the data-out wire from so_oe
`timescale 1ns/1ps
interface rpc_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    modport dev  (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface

// >>> rpc_flash_dev.sv
// Purpose: Flash-side read-parameter command interpreter
// Assumes: Link pins sampled by hclk through two flops; SPI mode 0/3
// Notes:   Array data comes from the user side by address
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module rpc_flash_dev #(
    parameter logic [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
    parameter int         AW        = 24
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    rpc_link_if.dev            link,
    input  wire logic          dedicated_reset_n,
    input  wire logic          shared_pin_n,
    input  wire logic          busy,
    input  wire logic          prot_err_set,
    input  wire logic          prog_err_set,
    input  wire logic          erase_err_set,
    input  wire logic [7:0]    array_data,
    output logic [AW-1:0]      array_addr,
    output logic               device_reset,
    output logic               hold_active,
    output logic [3:0]         dummy_cycles,
    output logic [2:0]         drive_strength,
    output logic [7:0]         nv_read_params,
    output logic [7:0]         nv_ext_params,
    output logic               write_enable_latch
);
    typedef enum logic [2:0] {
        ST_CMD   = 3'b000,
        ST_PARAM = 3'b001,
        ST_ADDR  = 3'b011,
        ST_OUT   = 3'b010,
        ST_DUMMY = 3'b110,
        ST_IGN   = 3'b111
    } rpc_state_e;

    // ----------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------
    logic [1:0] cs_s_q, sck_s_q, si_s_q, rstp_s_q, shp_s_q;
    logic       sck_d1_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_s_q   <= 2'b11;
            sck_s_q  <= 2'b00;
            si_s_q   <= 2'b00;
            sck_d1_q <= 1'b0;
            rstp_s_q <= 2'b11;
            shp_s_q  <= 2'b11;
        end else begin
            cs_s_q   <= {cs_s_q[0], link.cs_n};
            sck_s_q  <= {sck_s_q[0], link.sck};
            si_s_q   <= {si_s_q[0], link.si};
            sck_d1_q <= sck_s_q[1];
            rstp_s_q <= {rstp_s_q[0], dedicated_reset_n};
            shp_s_q  <= {shp_s_q[0], shared_pin_n};
        end
    end
    wire cs_hi   = cs_s_q[1];
    wire sck_r   = sck_s_q[1] & ~sck_d1_q;
    wire sck_f   = ~sck_s_q[1] & sck_d1_q;
    wire si_b    = si_s_q[1];

    // ----------------------------------------
    // Registers and shift state
    // ----------------------------------------
    rpc_state_e  st_q;
    logic [7:0]  sh_q, op_q, rp_q, rpnv_q, ep_q, epnv_q, obyte_q;
    logic [2:0]  bit_q;
    logic [1:0]  byte_q;
    logic [AW-1:0] addr_q;
    logic        wel_q, pend_q, so_q, oe_q, cs_d1_q;
    logic [7:0]  pval_q;

    wire [7:0] sh_next  = {sh_q[6:0], si_b};
    wire [AW-1:0] addr_in = AW'({addr_q, sh_next});
    wire       byte_done = sck_r && (bit_q == 3'd7);
    wire       wrap_en  = rp_q[rpc_pkg::RP_WRAP_EN_BIT];
    // Burst mask: 8,16,32,64 bytes
    wire [AW-1:0] wmask = AW'((8 << rp_q[1:0]) - 1);

    function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a, input logic w,
                                                input logic [AW-1:0] m);
        next_addr = w ? ((a & ~m) | ((a + 1'b1) & m)) : a + 1'b1;
    endfunction

    wire set_cmd = (op_q == rpc_pkg::CMD_SRP_NV) || (op_q == rpc_pkg::CMD_SRP_VW)
                || (op_q == rpc_pkg::CMD_SRP_VF) || (op_q == rpc_pkg::CMD_SEP_NV)
                || (op_q == rpc_pkg::CMD_SEP_V);
    wire cs_rise = cs_hi & ~cs_d1_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q    <= ST_CMD;
            sh_q    <= 8'h00;
            op_q    <= 8'h00;
            bit_q   <= 3'd0;
            byte_q  <= 2'd0;
            addr_q  <= '0;
            obyte_q <= 8'h00;
            so_q    <= 1'b0;
            oe_q    <= 1'b0;
            pend_q  <= 1'b0;
            pval_q  <= 8'h00;
            cs_d1_q <= 1'b1;
        end else begin
            cs_d1_q <= cs_hi;
            if (cs_hi) begin
                st_q  <= ST_CMD;
                bit_q <= 3'd0;
                oe_q  <= 1'b0;
            end else begin
                if (sck_r) begin
                    sh_q  <= sh_next;
                    bit_q <= bit_q + 3'd1;
                end
                if (sck_f && st_q == ST_OUT) begin
                    so_q    <= obyte_q[7 - bit_q];
                    oe_q    <= 1'b1;
                end
                if (byte_done) begin
                    case (st_q)
                        ST_CMD: begin
                            op_q   <= sh_next;
                            byte_q <= 2'd0;
                            pend_q <= 1'b0;
                            if (sh_next == rpc_pkg::CMD_RD_RP) begin
                                st_q <= ST_OUT;
                                obyte_q <= rp_q;
                            end else if (sh_next == rpc_pkg::CMD_RD_EP) begin
                                st_q <= ST_OUT;
                                obyte_q <= ep_q | {7'd0, busy};
                            end else if (sh_next == rpc_pkg::CMD_LEG_ID)
                                st_q <= busy ? ST_IGN : ST_DUMMY;
                            else if (sh_next == rpc_pkg::CMD_READ)
                                st_q <= ST_ADDR;
                            else
                                st_q <= ST_PARAM;
                        end
                        ST_PARAM: begin
                            pval_q <= sh_next;
                            pend_q <= set_cmd;
                            st_q   <= ST_IGN;
                        end
                        ST_ADDR: begin
                            addr_q <= addr_in;
                            byte_q <= byte_q + 2'd1;
                            if (byte_q == 2'(rpc_pkg::ADDR_BYTES - 1)) begin
                                st_q <= ST_OUT;
                                obyte_q <= array_data;
                            end
                        end
                        ST_DUMMY: begin
                            byte_q <= byte_q + 2'd1;
                            if (byte_q == 2'(rpc_pkg::LEG_ID_DUMMY_BYTES - 1)) begin
                                st_q <= ST_OUT;
                                obyte_q <= DEVICE_ID;
                            end
                        end
                        ST_OUT: begin
                            if (op_q == rpc_pkg::CMD_READ) begin
                                addr_q  <= next_addr(addr_q, wrap_en, wmask);
                                obyte_q <= array_data;
                            end else if (op_q == rpc_pkg::CMD_RD_EP)
                                obyte_q <= ep_q | {7'd0, busy};
                            // Other reads repeat the same byte
                        end
                        default: st_q <= ST_IGN;
                    endcase
                end
            end
            if (cs_rise)
                pend_q <= 1'b0;
        end
    end
    // Array address looks one ahead while streaming
    // Last address byte: start address already complete for first fetch
    assign array_addr = (st_q == ST_OUT) ? next_addr(addr_q, wrap_en, wmask)
                      : (st_q == ST_ADDR) ? addr_in : addr_q;

    // ----------------------------------------
    // Register updates at deselect; error flags set in any cycle
    // ----------------------------------------
    wire do_rpnv = cs_rise && pend_q && op_q == rpc_pkg::CMD_SRP_NV && wel_q;
    wire do_rpv  = cs_rise && pend_q && ((op_q == rpc_pkg::CMD_SRP_VW && wel_q)
                                     || op_q == rpc_pkg::CMD_SRP_VF);
    wire do_epnv = cs_rise && pend_q && op_q == rpc_pkg::CMD_SEP_NV && wel_q;
    wire do_epv  = cs_rise && pend_q && op_q == rpc_pkg::CMD_SEP_V;
    wire do_clr  = cs_rise && op_q == rpc_pkg::CMD_CLR_EP && st_q != ST_CMD;
    wire do_wren = cs_rise && op_q == rpc_pkg::CMD_WREN && st_q == ST_PARAM;
    wire [7:0] err_set = {4'd0, erase_err_set, prog_err_set, prot_err_set, 1'b0};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rp_q   <= rpc_pkg::RP_RESET;
            rpnv_q <= rpc_pkg::RP_RESET;
            ep_q   <= rpc_pkg::EP_RESET;
            epnv_q <= rpc_pkg::EP_RESET;
            wel_q  <= 1'b0;
        end else begin
            if (do_rpnv) begin
                rpnv_q <= pval_q;
                rp_q   <= pval_q;
            end else if (do_rpv)
                rp_q <= pval_q;
            if (do_epnv)
                epnv_q <= pval_q & rpc_pkg::EP_ODS_MASK;
            // Drive bits load, error flags: set beats clear
            ep_q <= ((do_epnv || do_epv) ? ((ep_q & ~rpc_pkg::EP_ODS_MASK) | (pval_q & rpc_pkg::EP_ODS_MASK))
                                          : ep_q)
                    & ~(do_clr ? rpc_pkg::EP_ERR_MASK : 8'h00) | err_set;
            if (do_wren)
                wel_q <= 1'b1;
            else if (do_rpnv || do_epnv || (do_rpv && op_q == rpc_pkg::CMD_SRP_VW))
                wel_q <= 1'b0;
        end
    end

    assign link.so            = so_q;
    assign link.so_oe         = oe_q && !cs_hi;
    assign hold_active        = rp_q[rpc_pkg::RP_HOLD_SEL_BIT] ? 1'b0 : ~shp_s_q[1];
    assign device_reset       = ~rstp_s_q[1]
                              | (rp_q[rpc_pkg::RP_HOLD_SEL_BIT] & ~shp_s_q[1]);
    assign dummy_cycles       = rp_q[rpc_pkg::RP_DUMMY_LSB +: 4];
    assign drive_strength     = ep_q[rpc_pkg::EP_ODS_LSB +: 3];
    assign nv_read_params     = rpnv_q;
    assign nv_ext_params      = epnv_q;
    assign write_enable_latch = wel_q;
endmodule

// >>> rpc_host_ctrl.sv
// Purpose: Controller end: AHB-Lite registers drive byte transfers on the link
// Assumes: One slave on the bus, single word transfers
// Notes:   Software frames commands with the select bit of the control register
`timescale 1ns/1ps
module rpc_host_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    rpc_link_if.host         link
);
    typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_LOW = 2'b01, HS_HIGH = 2'b11} rpc_hstate_e;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic        wr_q, rd_q;
    logic [7:0]  a_q;
    logic [7:0]  tx_q, rx_q, div_q, cnt_q;
    logic        sel_q;
    logic [2:0]  bit_q;
    logic [1:0]  so_s_q;
    logic        sck_q, busy_q;
    rpc_hstate_e st_q;
    wire take  = hsel && hready && htrans[1];
    wire w_tx  = wr_q && a_q == rpc_pkg::HR_TX;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            a_q  <= 8'h00;
        end else begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            if (take)
                a_q <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_comb begin
        case (a_q)
            rpc_pkg::HR_CTRL:   hrdata = {31'd0, sel_q};
            rpc_pkg::HR_RX:     hrdata = {24'd0, rx_q};
            rpc_pkg::HR_STATUS: hrdata = {31'd0, busy_q};
            rpc_pkg::HR_DIV:    hrdata = {24'd0, div_q};
            default:            hrdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // Byte shifter, mode 0, MSB first
    // ----------------------------------------
    wire tick = (cnt_q == 8'd0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q  <= 1'b0;
            div_q  <= rpc_pkg::DIV_RESET;
            tx_q   <= 8'h00;
            rx_q   <= 8'h00;
            cnt_q  <= 8'h00;
            bit_q  <= 3'd0;
            sck_q  <= 1'b0;
            busy_q <= 1'b0;
            so_s_q <= 2'b00;
            st_q   <= HS_IDLE;
        end else begin
            // Released data line reads high
            so_s_q <= {so_s_q[0], link.so | ~link.so_oe};
            if (wr_q && a_q == rpc_pkg::HR_CTRL && !busy_q)
                sel_q <= hwdata[0];
            if (wr_q && a_q == rpc_pkg::HR_DIV)
                div_q <= (hwdata[7:0] < 8'd2) ? 8'd2 : hwdata[7:0];
            cnt_q <= tick ? div_q - 8'd1 : cnt_q - 8'd1;
            case (st_q)
                HS_IDLE: if (w_tx && !busy_q && sel_q) begin
                    tx_q   <= hwdata[7:0];
                    busy_q <= 1'b1;
                    bit_q  <= 3'd0;
                    cnt_q  <= div_q - 8'd1;
                    st_q   <= HS_LOW;
                end
                HS_LOW: if (tick) begin
                    sck_q <= 1'b1;
                    st_q  <= HS_HIGH;
                end
                HS_HIGH: if (tick) begin
                    // Sample late in high phase to cover sync delay
                    rx_q  <= {rx_q[6:0], so_s_q[1]};
                    sck_q <= 1'b0;
                    tx_q  <= {tx_q[6:0], 1'b0};
                    bit_q <= bit_q + 3'd1;
                    if (bit_q == 3'd7) begin
                        busy_q <= 1'b0;
                        st_q   <= HS_IDLE;
                    end else
                        st_q <= HS_LOW;
                end
                default: st_q <= HS_IDLE;
            endcase
        end
    end
    assign link.cs_n = ~sel_q;
    assign link.sck  = sck_q;
    assign link.si   = tx_q[7];
endmodule

// >>> rpc_link_sva.sv
// Purpose: Checker on the serial link between the two ends
// Assumes: Mode 0 link, every line seen at hclk
// Notes:   Helper logic counts sck rises and keeps the opcode
`timescale 1ns/1ps
module rpc_link_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic       sck_q;
    logic [5:0] cnt_q;
    logic [7:0] op_q;
    wire        rise_w = sck && !sck_q;
    wire        set_w  = op_q inside {8'h06, 8'h65, 8'h63, 8'hC0, 8'h85, 8'h83, 8'h82};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_q <= 1'b0;
            cnt_q <= 6'h00;
            op_q  <= 8'h00;
        end else begin
            sck_q <= sck;
            if (cs_n) begin
                cnt_q <= 6'h00;
            end else if (rise_w && cnt_q != 6'h3F) begin
                cnt_q <= cnt_q + 6'h01;
            end
            if (!cs_n && rise_w && cnt_q < 6'h08) begin
                op_q <= {op_q[6:0], si};
            end
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ----
    // Link rules
    // ----
    sck_idle_a: assert property (cs_n |-> !sck)
        else $error("sck high while deselected");
    oe_idle_a: assert property (cs_n [*5] |-> !so_oe)
        else $error("so driven while deselected");
    oe_opcode_a: assert property (!cs_n && cnt_q < 6'h08 |-> !so_oe)
        else $error("so driven during opcode");
    set_quiet_a: assert property (!cs_n && cnt_q > 6'h07 && set_w |-> !so_oe)
        else $error("so driven in set frame");
    id_dummy_a: assert property (!cs_n && cnt_q < 6'h20 && op_q == 8'hAB |-> !so_oe)
        else $error("id out before dummy bytes");
    sck_high_a: assert property ($rose(sck) |=> sck [*2])
        else $error("sck high phase too short");
    sck_low_a: assert property ($fell(sck) |=> !sck [*2])
        else $error("sck low phase too short");
    si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
        else $error("si moved while sck high");
    so_hold_a: assert property (so_oe && sck && $past(sck) |-> $stable(so))
        else $error("so moved while sck high");
    cover property (!cs_n && set_w && cnt_q == 6'h10);
    cover property (so_oe && op_q == 8'hAB);
    cover property (so_oe && op_q == 8'h03 && cnt_q > 6'h30);
endmodule

// >>> read_param_config_cmds_tb.sv
// Purpose: Bench for both link ends, driven over AHB-Lite
// Assumes: Zero-wait slave, divider left at reset value
// Notes:   Array byte is address low byte plus middle byte
`timescale 1ns/1ps
module read_param_config_cmds_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    wire logic   hready = hreadyout;
    logic        dedicated_reset_n = 1'b1;
    logic        shared_pin_n = 1'b1;
    logic        busy = 1'b0;
    logic [2:0]  err_set = 3'b000;
    logic [23:0] array_addr;
    wire [7:0]   array_data = array_addr[7:0] + array_addr[15:8];
    logic        device_reset;
    logic        hold_active;
    logic [3:0]  dummy_cycles;
    logic [2:0]  drive_strength;
    logic [7:0]  nv_read_params;
    logic [7:0]  nv_ext_params;
    logic        write_enable_latch;
    logic [7:0]  tx_b [8];
    logic [7:0]  rx_b [8];
    logic [31:0] r;
    int          oe_cnt = 0;
    int          oe_base = 0;
    int          mismatches = 0;
    int          check_count = 0;
    rpc_link_if link ();
    rpc_host_ctrl u_rpc_host_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(link));
    // Arbitrary identifier value
    rpc_flash_dev #(.DEVICE_ID(8'h3C)) u_rpc_flash_dev (
        .hclk(hclk), .hresetn(hresetn), .link(link), .dedicated_reset_n(dedicated_reset_n),
        .shared_pin_n(shared_pin_n), .busy(busy), .prot_err_set(err_set[0]),
        .prog_err_set(err_set[1]), .erase_err_set(err_set[2]), .array_data(array_data),
        .array_addr(array_addr), .device_reset(device_reset), .hold_active(hold_active),
        .dummy_cycles(dummy_cycles), .drive_strength(drive_strength),
        .nv_read_params(nv_read_params), .nv_ext_params(nv_ext_params),
        .write_enable_latch(write_enable_latch));
    rpc_link_sva u_rpc_link_sva (
        .hclk(hclk), .hresetn(hresetn), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
        .so(link.so), .so_oe(link.so_oe));
    initial begin
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (link.so_oe === 1'b1) begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    // ----
    // Tasks
    // ----
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        end_of_test();
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 9);
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 18);
        q = hrdata;
        if (hready !== 1'b1) begin
            hang();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        ahb(1'b0, a, 32'h0, q);
    endtask
    task automatic frame(input int n);
        int k;
        wr(rpc_pkg::HR_CTRL, 32'h1);
        for (int i = 0; i < n; i++) begin
            wr(rpc_pkg::HR_TX, {24'h0, tx_b[i]});
            k = 0;
            do begin
                rd(rpc_pkg::HR_STATUS, r);
                k++;
            end while (r[0] !== 1'b0 && k < 99);
            if (k >= 99) begin
                hang();
            end
            rd(rpc_pkg::HR_RX, r);
            rx_b[i] = r[7:0];
        end
        wr(rpc_pkg::HR_CTRL, 32'h0);
        repeat (8) @(posedge hclk);
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] b, input int n);
        tx_b[0] = op;
        for (int i = 1; i < 8; i++) begin
            tx_b[i] = b;
        end
        frame(n);
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        repeat (100000) @(posedge hclk);
        hang();
    end
    initial begin
        logic [7:0] lm;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        wr(8'h40, 32'h1);
        rd(8'h40, r);
        chk("unmapped", r, 32'h0);
        chk("hresp", hresp, 1'b0);
        rd(rpc_pkg::HR_DIV, r);
        chk("div", r, {24'h0, rpc_pkg::DIV_RESET});
        cmd(8'h61, 8'h00, 2);
        chk("rp rst", rx_b[1], rpc_pkg::RP_RESET);
        cmd(8'h81, 8'h00, 2);
        chk("ep rst", rx_b[1], rpc_pkg::EP_RESET);
        cmd(8'hC0, 8'h8D, 2);
        shared_pin_n <= 1'b0;
        cmd(8'h63, 8'h06, 2);
        cmd(8'h61, 8'h00, 2);
        chk("c0 set", rx_b[1], 8'h8D);
        chk("wel c0", write_enable_latch, 1'b0);
        chk("dummy", dummy_cycles, 4'h1);
        chk("pin rst", {device_reset, hold_active}, 2'b10);
        cmd(8'h06, 8'h00, 1);
        chk("wel", write_enable_latch, 1'b1);
        cmd(8'h63, 8'h06, 2);
        cmd(8'h61, 8'h00, 2);
        chk("63 set", rx_b[1], 8'h06);
        chk("pin hold", {device_reset, hold_active}, 2'b01);
        dedicated_reset_n <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("ded rst", {device_reset, hold_active}, 2'b11);
        dedicated_reset_n <= 1'b1;
        shared_pin_n <= 1'b1;
        cmd(8'h65, 8'h07, 2);
        cmd(8'h61, 8'h00, 2);
        chk("65 no wel", rx_b[1], 8'h06);
        cmd(8'h06, 8'h00, 1);
        cmd(8'h65, 8'h47, 2);
        cmd(8'h61, 8'h00, 2);
        chk("nv rp", nv_read_params, 8'h47);
        chk("rp copy", rx_b[1], 8'h47);
        for (int p = 7; p >= 0; p--) begin
            cmd(8'hC0, p[7:0], 2);
            tx_b = '{8'h03, 8'h00, 8'h01, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00};
            frame(7);
            lm = (8'h08 << p[1:0]) - 8'h01;
            chk("rd0", rx_b[4], 8'hFF);
            chk("rd1", rx_b[5], 8'h00);
            chk("rd2", rx_b[6], p[2] ? (8'hFE & ~lm) + 8'h01 : 8'h02);
        end
        cmd(8'h83, 8'h40, 2);
        cmd(8'h81, 8'h00, 2);
        chk("ep v", rx_b[1], 8'h40);
        chk("ods", drive_strength, 3'b010);
        cmd(8'h06, 8'h00, 1);
        cmd(8'h85, 8'hA0, 2);
        cmd(8'h81, 8'h00, 2);
        chk("ep nv", nv_ext_params & rpc_pkg::EP_ODS_MASK, 8'hA0);
        chk("ep copy", rx_b[1], 8'hA0);
        err_set <= 3'b111;
        @(posedge hclk);
        err_set <= 3'b000;
        busy <= 1'b1;
        cmd(8'h81, 8'h00, 2);
        chk("ep busy", rx_b[1], 8'hAF);
        busy <= 1'b0;
        cmd(8'h82, 8'h00, 1);
        cmd(8'h81, 8'h00, 2);
        chk("ep clr", rx_b[1], 8'hA0);
        cmd(8'hAB, 8'h00, 6);
        chk("id0", rx_b[4], 8'h3C);
        chk("id1", rx_b[5], 8'h3C);
        busy <= 1'b1;
        oe_base = oe_cnt;
        cmd(8'hAB, 8'h00, 6);
        chk("id busy", oe_cnt - oe_base, 0);
        chk("id busy rx", rx_b[4], 8'hFF);
        end_of_test();
    end
endmodule
